// File: core/rsic_core.sv
// Reset initial-state control: reset-cause flags and initial core state
// Operation
// RULE1: Power-on clears both reset-cause flags
// RULE2: Pin or low-voltage reset keeps both flags
// RULE3: Running watchdog reset sets expiry flag only
// RULE4: Halted watchdog reset sets both flags
// RULE5: Flags live in status, software reads them
// RULE6: Reset disables every interrupt enable
// RULE7: Watchdog cleared, then counts without software
// RULE8: Reset switches timer/event counter off
// RULE9: Reset clears the timer prescaler
// RULE10: Ports and directions go all ones
// RULE11: Stack pointer addresses top of stack
// RULE12: Separate initial set per reset kind
// RULE13: Every reset forces program counter zero
// RULE14: Halted watchdog clears PC, SP only; the code also clears the watchdog counter
// RULE15: Merge sources, remember kind for selection
`timescale 1ns/100ps
module rsic_core
    import rsic_pkg::*;
#(
    parameter int PORT_W = RSIC_PORT_W,
    parameter int INT_W  = RSIC_INT_W
)(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire rsic_src_t             src_async,
    input  wire logic                  halted,
    input  wire logic                  enter_power_down,
    input  wire logic                  wd_clear,
    input  wire logic                  flags_we,
    input  wire rsic_flags_t           flags_wdata,
    output rsic_flags_t                flags,
    output rsic_kind_t                 last_kind,
    output logic                       core_reset,
    output logic                       periph_reset,
    output logic [RSIC_PC_W-1:0]       pc_init,
    output logic [RSIC_SP_W-1:0]       sp_init,
    output logic [INT_W-1:0]           int_enable,
    output logic [RSIC_WD_W-1:0]       watchdog_counter,
    output logic                       timer_run,
    output logic [RSIC_PRE_W-1:0]      prescaler,
    output logic [PORT_W-1:0]          port_data,
    output logic [PORT_W-1:0]          port_dir
);
    rsic_src_t   src;
    rsic_state_t state_q, state_d;
    rsic_kind_t  kind_q, kind_d;
    rsic_flags_t flags_q, flags_d;
    logic [1:0]  hold_q, hold_d;
    logic [INT_W-1:0]      inten_q, inten_d;
    logic [RSIC_WD_W-1:0]  wd_q, wd_d;
    logic                  trun_q, trun_d;
    logic [RSIC_PRE_W-1:0] pre_q, pre_d;
    logic [PORT_W-1:0]     pdat_q, pdat_d;
    logic [PORT_W-1:0]     pdir_q, pdir_d;
    logic                  req;
    rsic_kind_t            req_kind;
    logic                  apply;
    logic                  full_init;

    // Sources are asynchronous to clk, so they are synchronised first
    rsic_sync #(.W(4)) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   (src_async),
        .dout  (src)
    );

    // Priority: power-on, then pin, low voltage, watchdog
    function automatic rsic_kind_t rsic_classify(input rsic_src_t s, input logic h);
        if (s.power_on)                 return RSIC_KIND_POWER;
        else if (s.external_clear_pin)  return RSIC_KIND_PIN;
        else if (s.low_voltage_trip)    return RSIC_KIND_LOWV;
        else if (s.watchdog_expired)    return h ? RSIC_KIND_WD_HALT : RSIC_KIND_WD_RUN;
        else                            return RSIC_KIND_NONE;
    endfunction : rsic_classify

    assign req       = |src; // RULE15
    assign req_kind  = rsic_classify(src, halted);
    assign apply     = (state_q == RSIC_ST_APPLY);
    assign full_init = (kind_q != RSIC_KIND_WD_HALT); // RULE12

    // Sequencer: hold while a source stands, apply the kind's set once
    always_comb
    begin
        state_d = state_q;
        kind_d  = kind_q;
        hold_d  = hold_q;
        case (state_q)
            RSIC_ST_RUN:
            begin
                if (req)
                begin
                    kind_d  = req_kind; // RULE15
                    state_d = RSIC_ST_HOLD;
                    hold_d  = RSIC_HOLD_CYCLES;
                end
            end
            RSIC_ST_HOLD:
            begin
                // A stronger source arriving during hold takes over
                if (req && req_kind < kind_q && req_kind != RSIC_KIND_NONE)
                    kind_d = req_kind;
                if (req)
                    hold_d = RSIC_HOLD_CYCLES;
                else if (hold_q != 2'h0)
                    hold_d = hold_q - 2'h1;
                else
                    state_d = RSIC_ST_APPLY;
            end
            RSIC_ST_APPLY:
                state_d = RSIC_ST_RUN;
            default:
                state_d = RSIC_ST_RUN;
        endcase
    end

    // Reset-cause flags; hardware events win over a software write
    always_comb
    begin
        flags_d = flags_q;
        if (flags_we)
            flags_d = flags_wdata; // RULE5
        if (enter_power_down)
            flags_d.power_down_flag = 1'b1; // RULE5
        if (apply)
        begin
            case (kind_q)
                RSIC_KIND_POWER:
                    flags_d = '{guard_expiry_flag: 1'b0, power_down_flag: 1'b0}; // RULE1
                RSIC_KIND_PIN, RSIC_KIND_LOWV:
                    flags_d = flags_q; // RULE2
                RSIC_KIND_WD_RUN:
                    flags_d.guard_expiry_flag = 1'b1; // RULE3
                RSIC_KIND_WD_HALT:
                    flags_d = '{guard_expiry_flag: 1'b1, power_down_flag: 1'b1}; // RULE4
                default:
                    flags_d = flags_q;
            endcase
        end
    end

    // Peripheral initial state per reset kind
    always_comb
    begin
        inten_d = inten_q;
        trun_d  = trun_q;
        pre_d   = pre_q + 7'h1;
        pdat_d  = pdat_q;
        pdir_d  = pdir_q;
        wd_d    = wd_q + 16'h1; // RULE7
        if (wd_clear)
            wd_d = '0;
        if (apply)
        begin
            wd_d = '0; // RULE7
            if (full_init)
            begin
                inten_d = '0; // RULE6
                trun_d  = 1'b0; // RULE8
                pre_d   = '0; // RULE9
                pdat_d  = '1; // RULE10
                pdir_d  = '1; // RULE10
            end
        end
        if (!trun_q && !apply)
            pre_d = pre_q; // Prescaler idles while the timer is off and no set is being applied
    end

    // All registers: power reset pin gives the power-on set
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= RSIC_ST_RUN;
            kind_q  <= RSIC_KIND_POWER;
            hold_q  <= 2'h0;
            flags_q <= '0; // RULE1
            inten_q <= RSIC_INT_RESET[INT_W-1:0]; // RULE6
            wd_q    <= '0;
            trun_q  <= 1'b0;
            pre_q   <= '0;
            pdat_q  <= '1;
            pdir_q  <= '1;
        end
        else
        begin
            state_q <= state_d;
            kind_q  <= kind_d;
            hold_q  <= hold_d;
            flags_q <= flags_d;
            inten_q <= inten_d;
            wd_q    <= wd_d;
            trun_q  <= trun_d;
            pre_q   <= pre_d;
            pdat_q  <= pdat_d;
            pdir_q  <= pdir_d;
        end
    end

    assign flags            = flags_q;
    assign last_kind        = kind_q;
    assign core_reset       = (state_q != RSIC_ST_RUN); // RULE13
    assign periph_reset     = core_reset && full_init; // RULE12
    assign pc_init          = '0; // RULE13 RULE14
    assign sp_init          = RSIC_SP_TOP; // RULE11 RULE14
    assign int_enable       = inten_q;
    assign watchdog_counter = wd_q;
    assign timer_run        = trun_q;
    assign prescaler        = pre_q;
    assign port_data        = pdat_q;
    assign port_dir         = pdir_q;

    property p_power_flags;
        @(posedge clk) disable iff (reset)
        apply && kind_q == RSIC_KIND_POWER |=> flags_q == 2'b00;
    endproperty
    a_power_flags: assert property (p_power_flags) else $error("flags not cleared"); // RULE1

    property p_pin_flags;
        @(posedge clk) disable iff (reset)
        apply && (kind_q == RSIC_KIND_PIN || kind_q == RSIC_KIND_LOWV) && !flags_we
            && !enter_power_down |=> $stable(flags_q);
    endproperty
    a_pin_flags: assert property (p_pin_flags) else $error("flags changed"); // RULE2

    property p_wdrun_flags;
        @(posedge clk) disable iff (reset)
        apply && kind_q == RSIC_KIND_WD_RUN && !flags_we && !enter_power_down
            |=> flags_q.guard_expiry_flag
                && flags_q.power_down_flag == $past(flags_q.power_down_flag);
    endproperty
    a_wdrun_flags: assert property (p_wdrun_flags) else $error("run watchdog flags"); // RULE3

    property p_wdhalt_flags;
        @(posedge clk) disable iff (reset)
        apply && kind_q == RSIC_KIND_WD_HALT |=> flags_q == 2'b11;
    endproperty
    a_wdhalt_flags: assert property (p_wdhalt_flags) else $error("halt watchdog flags"); // RULE4

    property p_pd_set;
        @(posedge clk) disable iff (reset)
        enter_power_down |=> flags_q.power_down_flag;
    endproperty
    a_pd_set: assert property (p_pd_set) else $error("power-down flag lost"); // RULE5

    sequence s_full_apply;
        apply && full_init;
    endsequence

    property p_init_set;
        @(posedge clk) disable iff (reset)
        s_full_apply |=> inten_q == '0 && !trun_q && pre_q == '0 && pdat_q == '1 && pdir_q == '1;
    endproperty
    a_init_set: assert property (p_init_set) else $error("initial set wrong"); // RULE6

    property p_wd_runs;
        @(posedge clk) disable iff (reset)
        apply ##1 !wd_clear && !apply |=> wd_q == 16'h1;
    endproperty
    a_wd_runs: assert property (p_wd_runs) else $error("watchdog not counting"); // RULE7

    property p_halt_keep;
        @(posedge clk) disable iff (reset)
        apply && !full_init |=> $stable(pdat_q) && $stable(inten_q) && $stable(trun_q);
    endproperty
    a_halt_keep: assert property (p_halt_keep) else $error("halt reset altered state"); // RULE14

    property p_core_reset;
        @(posedge clk) disable iff (reset)
        state_q == RSIC_ST_RUN && req |=> core_reset [*2];
    endproperty
    a_core_reset: assert property (p_core_reset) else $error("core reset missing"); // RULE13
endmodule : rsic_core

// File: core/rsic_pkg.sv
// Reset-state package: reset kinds, reset values and the reset-cause carrier
package rsic_pkg;

    // Reset kinds, one per initial-value set
    typedef enum logic [2:0] {
        RSIC_KIND_NONE    = 3'b000,
        RSIC_KIND_POWER   = 3'b001,
        RSIC_KIND_PIN     = 3'b010,
        RSIC_KIND_LOWV    = 3'b011,
        RSIC_KIND_WD_RUN  = 3'b100,
        RSIC_KIND_WD_HALT = 3'b101
    } rsic_kind_t;

    // Sequencer states
    typedef enum logic [1:0] {
        RSIC_ST_RUN   = 2'b00,
        RSIC_ST_APPLY = 2'b01,
        RSIC_ST_HOLD  = 2'b10
    } rsic_state_t;

    // Raw reset sources as they arrive
    typedef struct packed {
        logic power_on;
        logic external_clear_pin;
        logic low_voltage_trip;
        logic watchdog_expired;
    } rsic_src_t;

    // Reset-cause flags held in the status register
    typedef struct packed {
        logic guard_expiry_flag;
        logic power_down_flag;
    } rsic_flags_t;

    localparam int         RSIC_PORT_W        = 8;
    localparam int         RSIC_PC_W          = 12;
    localparam int         RSIC_SP_W          = 3;
    localparam int         RSIC_WD_W          = 16;
    localparam int         RSIC_PRE_W         = 7;
    localparam int         RSIC_INT_W         = 8;
    localparam logic [7:0] RSIC_PORT_RESET    = 8'hff;
    localparam logic [7:0] RSIC_INT_RESET     = 8'h00;
    localparam logic [2:0] RSIC_SP_TOP        = 3'h0;
    localparam logic [1:0] RSIC_HOLD_CYCLES   = 2'h2;

endpackage : rsic_pkg

// File: core/rsic_sync.sv
// Two-flop synchroniser bank for asynchronous reset sources
`timescale 1ns/100ps
module rsic_sync
    import rsic_pkg::*;
#(
    parameter int W = 4
)(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // First stage feeds only the second stage
    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule : rsic_sync

// File: test/rsic_core_test.sv
// Self-checking bench for the reset initial-state control core
`timescale 1ns/100ps
module rsic_core_test;
    import rsic_pkg::*;

    logic                  clk;
    logic                  reset;
    rsic_src_t             src_async;
    logic                  halted;
    logic                  enter_power_down;
    logic                  wd_clear;
    logic                  flags_we;
    rsic_flags_t           flags_wdata;
    rsic_flags_t           flags;
    rsic_kind_t            last_kind;
    logic                  core_reset;
    logic                  periph_reset;
    logic [RSIC_PC_W-1:0]  pc_init;
    logic [RSIC_SP_W-1:0]  sp_init;
    logic [7:0]            int_enable;
    logic [RSIC_WD_W-1:0]  watchdog_counter;
    logic                  timer_run;
    logic [RSIC_PRE_W-1:0] prescaler;
    logic [7:0]            port_data;
    logic [7:0]            port_dir;
    int                    n_fail;
    int                    checks;
    int                    cycles;

    rsic_core uut (
        .clk              (clk),
        .reset            (reset),
        .src_async        (src_async),
        .halted           (halted),
        .enter_power_down (enter_power_down),
        .wd_clear         (wd_clear),
        .flags_we         (flags_we),
        .flags_wdata      (flags_wdata),
        .flags            (flags),
        .last_kind        (last_kind),
        .core_reset       (core_reset),
        .periph_reset     (periph_reset),
        .pc_init          (pc_init),
        .sp_init          (sp_init),
        .int_enable       (int_enable),
        .watchdog_counter (watchdog_counter),
        .timer_run        (timer_run),
        .prescaler        (prescaler),
        .port_data        (port_data),
        .port_dir         (port_dir)
    );

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard: whole run needs well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // Watchdog must advance by exactly one per cycle
    task automatic wd_counts();
        logic [15:0] w;
        w = watchdog_counter;
        @(negedge clk);
        check(watchdog_counter, w + 16'h0001);
    endtask : wd_counts

    // Initial set shared by power, pin, low-voltage and running watchdog
    task automatic full_set();
        check(int_enable, 16'h0000);
        check(timer_run, 16'h0000);
        check(prescaler, 16'h0000);
        check(port_data, 16'h00ff);
        check(port_dir, 16'h00ff);
        check(watchdog_counter, 16'h0000);
        wd_counts();
    endtask : full_set

    // Raise one or more sources, watch the sequence, release it
    task automatic do_reset(input logic [3:0] s, input logic hlt, input logic per_exp);
        int n;
        halted = hlt;
        src_async = rsic_src_t'(s);
        n = 0;
        while (core_reset !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(core_reset, 16'h0001);
        check(pc_init, 16'h0000);
        check(sp_init, 16'h0000);
        check(periph_reset, {15'h0000, per_exp});
        src_async = '0;
        n = 0;
        while (core_reset !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(core_reset, 16'h0000);
        halted = 1'b0;
    endtask : do_reset

    // Software flag write, one pulse
    task automatic write_flags(input logic [1:0] v);
        flags_wdata = rsic_flags_t'(v);
        flags_we = 1'b1;
        @(negedge clk);
        flags_we = 1'b0;
        check(flags, {14'h0000, v});
    endtask : write_flags

    task automatic t_after_power_on();
        check(flags, 16'h0000);
        check(last_kind, RSIC_KIND_POWER);
        full_set();
    endtask : t_after_power_on

    task automatic t_pin_and_lowv_keep();
        write_flags(2'b11);
        do_reset(4'b0100, 1'b0, 1'b1);
        check(flags, 16'h0003);
        check(last_kind, RSIC_KIND_PIN);
        full_set();
        write_flags(2'b01);
        do_reset(4'b0010, 1'b0, 1'b1);
        check(flags, 16'h0001);
        check(last_kind, RSIC_KIND_LOWV);
        full_set();
    endtask : t_pin_and_lowv_keep

    task automatic t_watchdog_kinds();
        write_flags(2'b00);
        do_reset(4'b0001, 1'b0, 1'b1);
        check(flags, 16'h0002);
        check(last_kind, RSIC_KIND_WD_RUN);
        full_set();
        do_reset(4'b0001, 1'b1, 1'b0);
        check(flags, 16'h0003);
        check(last_kind, RSIC_KIND_WD_HALT);
        check(port_data, 16'h00ff);
        check(watchdog_counter, 16'h0000);
        wd_counts();
    endtask : t_watchdog_kinds

    task automatic t_power_wins();
        do_reset(4'b1101, 1'b0, 1'b1);
        check(flags, 16'h0000);
        check(last_kind, RSIC_KIND_POWER);
        full_set();
    endtask : t_power_wins

    task automatic t_live_events();
        write_flags(2'b00);
        enter_power_down = 1'b1;
        @(negedge clk);
        enter_power_down = 1'b0;
        check(flags, 16'h0001);
        repeat (5) @(negedge clk);
        wd_clear = 1'b1;
        @(negedge clk);
        wd_clear = 1'b0;
        check(watchdog_counter, 16'h0000);
        wd_counts();
    endtask : t_live_events

    // Mid-run power reset must clear flags set earlier and reload the full set
    task automatic t_mid_reset();
        write_flags(2'b11);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        check(flags, 16'h0000);
        check(last_kind, RSIC_KIND_POWER);
        full_set();
    endtask : t_mid_reset

    // Main sequence; inputs change on the falling edge only
    initial
    begin
        n_fail = 0;
        checks = 0;
        cycles = 0;
        reset = 1'b1;
        src_async = '0;
        halted = 1'b0;
        enter_power_down = 1'b0;
        wd_clear = 1'b0;
        flags_we = 1'b0;
        flags_wdata = '0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        // Watchdog starts counting at the first edge, so look before it
        t_after_power_on();
        repeat (3) @(negedge clk);
        t_pin_and_lowv_keep();
        t_watchdog_kinds();
        t_power_wins();
        t_live_events();
        t_mid_reset();
        end_of_test();
    end
endmodule : rsic_core_test
